/* pic_device.sv */
// eight-level priority interrupt controller end
`timescale 1ns/1ps
module pic_device
   import pic_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   pic_link_if.device link,
   // request lines
   input wire logic [7:0] irq_in,
   // mode view
   output logic level_mode,
   output logic nested_mode,
   output logic master_role,
   output logic special_mask_state
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'd0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
   function automatic logic [7:0] onehot(input logic [2:0] l);
      return 8'h01 << l;
   endfunction
   // ----------------------------------------
   // state
   // ----------------------------------------
   init_state_e st_reg, st_next;
   logic [7:0] first_reg, first_next;
   logic [7:0] vec_reg, vec_next;
   logic [7:0] opt_reg, opt_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] irr_reg, irr_next;
   logic [7:0] isr_reg, isr_next;
   logic [7:0] prev_reg, prev_next;
   logic sel_reg, sel_next;
   logic poll_reg, poll_next;
   logic smm_reg, smm_next;
   logic [7:0] rdata_next, vector_next;
   logic vvalid_next, int_next;
   logic [7:0] pend, d, fresh;
   logic [2:0] lvl;
   always_comb begin
      st_next = st_reg;
      first_next = first_reg;
      vec_next = vec_reg;
      opt_next = opt_reg;
      mask_next = mask_reg;
      isr_next = isr_reg;
      sel_next = sel_reg;
      poll_next = poll_reg;
      smm_next = smm_reg;
      d = link.wdata;
      prev_next = irq_in;
      // ----------------------------------------
      // request capture, edge or level
      // ----------------------------------------
      fresh = first_reg[first_level_bit] ? irq_in : (irq_in & ~prev_reg);
      irr_next = irr_reg | fresh;
      if (first_reg[first_level_bit]) begin
         irr_next = irr_next & irq_in;
      end
      // ----------------------------------------
      // priority resolution
      // ----------------------------------------
      pend = irr_reg & ~mask_reg;
      if (!smm_reg) begin
         pend = (isr_reg == 8'h00) ? pend : (pend & (onehot(lowest_set(isr_reg)) - 8'h01));
      end else begin
         pend = pend & ~isr_reg;
      end
      lvl = lowest_set(pend);
      vector_next = link.vector;
      vvalid_next = 1'b0;
      rdata_next = link.rdata;
      int_next = (pend != 8'h00);
      // ----------------------------------------
      // command decode
      // ----------------------------------------
      if (link.wr_stb && !link.addr_hi && d[first_flag_bit]) begin
         first_next = d;
         mask_next = zero_byte;
         isr_next = zero_byte;
         irr_next = zero_byte;
         smm_next = 1'b0;
         sel_next = 1'b0;
         opt_next = zero_byte;
         st_next = init_vector;
      end else if (link.wr_stb && link.addr_hi) begin
         case (st_reg)
            init_vector: begin
               vec_next = {d[7:3], 3'b000};
               if (!first_reg[first_single_bit]) begin
                  st_next = init_cascade;
               end else if (first_reg[first_need_opt_bit]) begin
                  st_next = init_options;
               end else begin
                  st_next = init_idle;
               end
            end
            init_cascade: begin
               st_next = first_reg[first_need_opt_bit] ? init_options : init_idle;
            end
            init_options: begin
               opt_next = d;
               st_next = init_idle;
            end
            init_idle: begin
               mask_next = d;
            end
            default: begin
               st_next = init_idle;
            end
         endcase
      end else if (link.wr_stb && !d[rb_sel_bit]) begin
         if (d[eoi_service_bit]) begin
            if (d[eoi_specific_bit]) begin
               isr_next = isr_reg & ~onehot(d[2:0]);
            end else if (isr_reg != 8'h00) begin
               isr_next = isr_reg & ~onehot(lowest_set(isr_reg));
            end
         end
      end else if (link.wr_stb) begin
         if (d[rb_smask_en_bit]) begin
            smm_next = d[rb_smask_bit];
         end
         if (d[rb_enable_bit]) begin
            sel_next = d[rb_select_bit];
         end
         poll_next = d[rb_poll_bit];
      end
      // ----------------------------------------
      // readback
      // ----------------------------------------
      if (link.rd_stb) begin
         if (link.addr_hi) begin
            rdata_next = mask_reg;
         end else if (poll_reg) begin
            rdata_next = {int_next, 4'h0, lvl};
            poll_next = 1'b0;
         end else begin
            rdata_next = sel_reg ? isr_reg : irr_reg;
         end
      end
      // ----------------------------------------
      // acknowledge, a fresh request wins
      // ----------------------------------------
      if (link.ack_stb && pend != 8'h00) begin
         vector_next = {vec_reg[7:3], lvl};
         vvalid_next = 1'b1;
         irr_next = irr_next & ~(onehot(lvl) & ~fresh);
         if (!opt_reg[opt_auto_bit]) begin
            isr_next = isr_next | onehot(lvl);
         end
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= init_idle;
         first_reg <= zero_byte;
         vec_reg <= zero_byte;
         opt_reg <= zero_byte;
         mask_reg <= mask_reset;
         irr_reg <= zero_byte;
         isr_reg <= zero_byte;
         prev_reg <= zero_byte;
         sel_reg <= 1'b0;
         poll_reg <= 1'b0;
         smm_reg <= 1'b0;
         link.rdata <= zero_byte;
         link.vector <= zero_byte;
         link.vector_valid <= 1'b0;
         link.int_req <= 1'b0;
         level_mode <= 1'b0;
         nested_mode <= 1'b0;
         master_role <= 1'b0;
         special_mask_state <= 1'b0;
      end else begin
         st_reg <= st_next;
         first_reg <= first_next;
         vec_reg <= vec_next;
         opt_reg <= opt_next;
         mask_reg <= mask_next;
         irr_reg <= irr_next;
         isr_reg <= isr_next;
         prev_reg <= prev_next;
         sel_reg <= sel_next;
         poll_reg <= poll_next;
         smm_reg <= smm_next;
         link.rdata <= rdata_next;
         link.vector <= vector_next;
         link.vector_valid <= vvalid_next;
         link.int_req <= int_next;
         level_mode <= first_next[first_level_bit];
         nested_mode <= opt_next[opt_nested_bit];
         master_role <= opt_next[opt_buffered_bit] & opt_next[opt_master_bit];
         special_mask_state <= smm_next;
      end
   end
endmodule // pic_device

/* pic_pkg.sv */
// shared constants and types for the priority interrupt controller link
// Contract
// - first init word at 020h, bit4 set
// - vector init word follows at 021h
// - acknowledge drives type top, level bottom
// - cascade word skipped in single mode
// - options word: auto end, nested bits
// - role bit honoured only when buffered
// - mask word at 021h, one inhibits
// - end-of-service word: rotate, specific, level (the device ignores the rotate bit)
// - readback word: poll and register select
// - readback select needs readback enable
// - special mask needs its enable
package pic_pkg;
   // ----------------------------------------
   // port addresses and field positions
   // ----------------------------------------
   localparam logic [7:0] addr_low = 8'h20;
   localparam logic [7:0] addr_high = 8'h21;
   localparam int first_flag_bit = 4;
   localparam int first_level_bit = 3;
   localparam int first_interval_bit = 2;
   localparam int first_single_bit = 1;
   localparam int first_need_opt_bit = 0;
   localparam int opt_nested_bit = 4;
   localparam int opt_buffered_bit = 3;
   localparam int opt_master_bit = 2;
   localparam int opt_auto_bit = 1;
   localparam int opt_cpu_bit = 0;
   localparam int eoi_rotate_bit = 7;
   localparam int eoi_specific_bit = 6;
   localparam int eoi_service_bit = 5;
   localparam int rb_sel_bit = 3;
   localparam int rb_smask_en_bit = 6;
   localparam int rb_smask_bit = 5;
   localparam int rb_poll_bit = 2;
   localparam int rb_enable_bit = 1;
   localparam int rb_select_bit = 0;
   localparam logic [7:0] mask_reset = 8'hff;
   localparam logic [7:0] zero_byte = 8'h00;
   // ----------------------------------------
   // controller register offsets on apb
   // ----------------------------------------
   localparam logic [7:0] reg_cmd = 8'h00;
   localparam logic [7:0] reg_status = 8'h04;
   localparam logic [7:0] reg_rdata = 8'h08;
   localparam int cmd_go_bit = 31;
   localparam int cmd_read_bit = 30;
   localparam int cmd_addr_bit = 8;
   // ----------------------------------------
   // states
   // ----------------------------------------
   typedef enum logic [3:0] {
      init_idle = 4'b0001,
      init_vector = 4'b0010,
      init_cascade = 4'b0100,
      init_options = 4'b1000
   } init_state_e;
   typedef enum logic [2:0] {
      host_idle = 3'b001,
      host_strobe = 3'b010,
      host_done = 3'b100
   } host_state_e;
endpackage

/* pic_link_if.sv */
// link between processor end and interrupt controller end
`timescale 1ns/1ps
interface pic_link_if;
   logic wr_stb;
   logic rd_stb;
   logic addr_hi;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack_stb;
   logic [7:0] vector;
   logic vector_valid;
   logic int_req;
   modport device (input wr_stb, input rd_stb, input addr_hi, input wdata, input ack_stb,
      output rdata, output vector, output vector_valid, output int_req);
   modport host (output wr_stb, output rd_stb, output addr_hi, output wdata, output ack_stb,
      input rdata, input vector, input vector_valid, input int_req);
endinterface

/* pic_host.sv */
// processor end: apb command registers drive the link
`timescale 1ns/1ps
module pic_host
   import pic_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   pic_link_if.host link,
   // acknowledge request
   input wire logic ack_req
);
   // ----------------------------------------
   // command sequencer
   // ----------------------------------------
   host_state_e st_reg, st_next;
   logic [7:0] rd_reg, rd_next;
   logic [7:0] vec_reg, vec_next;
   logic rd_op_reg, rd_op_next, pready_next;
   logic [31:0] prdata_next;
   logic access;
   logic wr_next, rs_next, hi_next, ack_next;
   logic [7:0] wd_next;
   assign access = psel && penable;
   always_comb begin
      st_next = st_reg;
      rd_next = rd_reg;
      vec_next = link.vector_valid ? link.vector : vec_reg;
      rd_op_next = rd_op_reg;
      wr_next = 1'b0;
      rs_next = 1'b0;
      ack_next = ack_req && !link.ack_stb;
      hi_next = link.addr_hi;
      wd_next = link.wdata;
      prdata_next = 32'h00000000;
      pready_next = access && !pready;
      case (st_reg)
         host_idle: begin
            if (access && pready && pwrite && paddr == reg_cmd && pwdata[cmd_go_bit]) begin
               hi_next = pwdata[cmd_addr_bit];
               wd_next = pwdata[7:0];
               rd_op_next = pwdata[cmd_read_bit];
               wr_next = !pwdata[cmd_read_bit];
               rs_next = pwdata[cmd_read_bit];
               st_next = host_strobe;
            end
         end
         host_strobe: begin
            st_next = host_done;
         end
         host_done: begin
            if (rd_op_reg) begin
               rd_next = link.rdata;
            end
            st_next = host_idle;
         end
         default: begin
            st_next = host_idle;
         end
      endcase
      if (access && !pwrite) begin
         case (paddr)
            reg_status: prdata_next = {22'h000000, link.int_req, st_reg != host_idle, vec_reg};
            reg_rdata: prdata_next = {24'h000000, rd_reg};
            default: prdata_next = 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= host_idle;
         rd_reg <= zero_byte;
         vec_reg <= zero_byte;
         rd_op_reg <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         link.wr_stb <= 1'b0;
         link.rd_stb <= 1'b0;
         link.addr_hi <= 1'b0;
         link.wdata <= zero_byte;
         link.ack_stb <= 1'b0;
      end else begin
         st_reg <= st_next;
         rd_reg <= rd_next;
         vec_reg <= vec_next;
         rd_op_reg <= rd_op_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= 1'b0;
         link.wr_stb <= wr_next;
         link.rd_stb <= rs_next;
         link.addr_hi <= hi_next;
         link.wdata <= wd_next;
         link.ack_stb <= ack_next;
      end
   end
endmodule // pic_host

/* pic_link_sva.sv */
// assertions on the processor to controller link
`timescale 1ns/1ps
module pic_link_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic addr_hi,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack_stb,
   input wire logic [7:0] vector,
   input wire logic vector_valid,
   input wire logic int_req
);
   // ----------------------------------------
   // init sequence tracking
   // ----------------------------------------
   logic vec_reg;
   logic vec_next;
   logic [1:0] left_reg;
   logic [1:0] left_next;
   logic [4:0] base_reg;
   logic [4:0] base_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   always_comb begin
      vec_next = vec_reg;
      left_next = left_reg;
      base_next = base_reg;
      mask_next = mask_reg;
      if (wr_stb && !addr_hi && wdata[4]) begin
         vec_next = 1'h1;
         left_next = {1'h0, !wdata[1]} + {1'h0, wdata[0]};
         mask_next = 8'h00;
      end else if (wr_stb && addr_hi) begin
         if (vec_reg) begin
            vec_next = 1'h0;
            base_next = wdata[7:3];
         end else if (left_reg != 2'h0) begin
            left_next = left_reg - 2'h1;
         end else begin
            mask_next = wdata;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_reg <= 1'h0;
         left_reg <= 2'h0;
         base_reg <= 5'h00;
         mask_reg <= 8'hff;
      end else begin
         vec_reg <= vec_next;
         left_reg <= left_next;
         base_reg <= base_next;
         mask_reg <= mask_next;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence mask_rd_s;
      rd_stb && addr_hi && !vec_reg && left_reg == 2'h0;
   endsequence
   sequence ack_s;
      ack_stb ##1 vector_valid;
   endsequence
   vec_top_a: assert property (vector_valid |-> vector[7:3] == base_reg)
      else $error("vector top bits differ from stored type");
   vec_cause_a: assert property (vector_valid |-> $past(ack_stb))
      else $error("vector valid without acknowledge");
   vec_pend_a: assert property (ack_s |-> $past(int_req))
      else $error("vector given with nothing pending");
   vec_hold_a: assert property (!ack_stb |=> $stable(vector))
      else $error("vector changed without acknowledge");
   mask_read_a: assert property (mask_rd_s |=> rdata == $past(mask_reg))
      else $error("upper read not the mask");
   mask_quiet_a: assert property ((mask_reg == 8'hff) [*2] |-> !int_req)
      else $error("request raised while all masked");
   strobe_pulse_a: assert property (wr_stb |=> !wr_stb && !rd_stb)
      else $error("write strobe longer than one cycle");
   ack_pulse_a: assert property (ack_stb |=> !ack_stb)
      else $error("acknowledge strobe longer than one cycle");
endmodule // pic_link_sva

/* priority_interrupt_programming_bench.sv */
// self-checking bench for the interrupt controller link
`timescale 1ns/1ps
module priority_interrupt_programming_bench
   import pic_pkg::*;
   ;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ack_req = 1'h0;
   logic [7:0] irq_in = 8'h00;
   logic level_mode;
   logic nested_mode;
   logic master_role;
   logic special_mask_state;
   logic [31:0] r;
   int fail_count = 0;
   int checks = 0;
   always #4 pclk = ~pclk;
   pic_link_if link ();
   pic_host pic_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host), .ack_req(ack_req));
   pic_device pic_device_i (.pclk(pclk), .presetn(presetn), .link(link.device),
      .irq_in(irq_in), .level_mode(level_mode), .nested_mode(nested_mode),
      .master_role(master_role), .special_mask_state(special_mask_state));
   pic_link_sva pic_link_sva_i (.pclk(pclk), .presetn(presetn), .wr_stb(link.wr_stb),
      .rd_stb(link.rd_stb), .addr_hi(link.addr_hi), .wdata(link.wdata), .rdata(link.rdata),
      .ack_stb(link.ack_stb), .vector(link.vector), .vector_valid(link.vector_valid),
      .int_req(link.int_req));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      r = prdata;
      chk(pslverr, 1'h0);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task automatic cmd(input logic rd, input logic hi, input logic [7:0] d);
      apb(1'h1, reg_cmd, {1'h1, rd, 21'h0, hi, d});
      repeat (4) @(posedge pclk);
   endtask
   task automatic rd8(input logic hi, input logic [7:0] exp);
      cmd(1'h1, hi, 8'h00);
      apb(1'h0, reg_rdata, 32'h0);
      chk({24'h0, r[7:0]}, {24'h0, exp});
   endtask
   task automatic init(input logic [7:0] fw, input logic [7:0] ow);
      cmd(1'h0, 1'h0, fw);
      cmd(1'h0, 1'h1, 8'h48);
      if (!fw[1]) cmd(1'h0, 1'h1, 8'h00);
      if (fw[0]) cmd(1'h0, 1'h1, ow);
   endtask
   task automatic ack(input logic [7:0] exp);
      ack_req <= 1'h1;
      @(posedge pclk);
      ack_req <= 1'h0;
      repeat (4) @(posedge pclk);
      apb(1'h0, reg_status, 32'h0);
      chk({24'h0, r[7:0]}, {24'h0, exp});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_modes();
      logic [7:0] fw [3] = '{8'h13, 8'h1b, 8'h11};
      logic [7:0] ow [3] = '{8'h05, 8'h0d, 8'h11};
      for (int i = 0; i < 3; i++) begin
         init(fw[i], ow[i]);
         chk(level_mode, fw[i][3]);
         chk(master_role, ow[i][3] & ow[i][2]);
         chk(nested_mode, ow[i][4]);
         rd8(1'h1, 8'h00);
      end
   endtask
   task automatic t_mask();
      init(8'h1b, 8'h01);
      cmd(1'h0, 1'h1, 8'ha5);
      rd8(1'h1, 8'ha5);
      cmd(1'h0, 1'h1, 8'hff);
      irq_in <= 8'h80;
      repeat (4) @(posedge pclk);
      chk(link.int_req, 1'h0);
      irq_in <= 8'h24;
      cmd(1'h0, 1'h1, 8'h00);
      chk(link.int_req, 1'h1);
   endtask
   task automatic t_service();
      ack(8'h4a);
      cmd(1'h0, 1'h0, 8'h0b);
      rd8(1'h0, 8'h04);
      cmd(1'h0, 1'h0, 8'h08);
      rd8(1'h0, 8'h04);
      chk(link.int_req, 1'h0);
      irq_in <= 8'h20;
      cmd(1'h0, 1'h0, 8'h20);
      ack(8'h4d);
      rd8(1'h0, 8'h20);
      cmd(1'h0, 1'h0, 8'h65);
      rd8(1'h0, 8'h00);
   endtask
   task automatic t_smask();
      logic [7:0] w [3] = '{8'h28, 8'h68, 8'h48};
      for (int i = 0; i < 3; i++) begin
         cmd(1'h0, 1'h0, w[i]);
         chk(special_mask_state, i == 1);
      end
      cmd(1'h0, 1'h0, 8'h0c);
      rd8(1'h0, 8'h85);
      apb(1'h0, 8'h0c, 32'h0);
      chk(r, 32'h0);
   endtask
   task automatic t_edge();
      init(8'h13, 8'h03);
      chk(link.int_req, 1'h0);
      irq_in <= 8'h28;
      repeat (4) @(posedge pclk);
      chk(link.int_req, 1'h1);
      ack(8'h4b);
      cmd(1'h0, 1'h0, 8'h0b);
      rd8(1'h0, 8'h00);
      chk(link.int_req, 1'h0);
   endtask
   task automatic conclude();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      t_modes();
      t_mask();
      t_service();
      t_smask();
      t_edge();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      conclude();
   end
endmodule // priority_interrupt_programming_bench
